// [pin_edge_sync.sv]
// shared constants and the pin synchroniser with bus condition detection
`timescale 1ns/1ps

package eeprom_pkg;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_MHZ = 200;                   // ref_clk rate
  localparam int TWC_MS = 5;                      // internal write cycle time
  localparam int TWC_CYCLES = TWC_MS * 1000 * CLK_MHZ;
  localparam int BUSY_W = 20;                     // busy counter width
  // -------------------------------------------------------------------
  // control byte codes and bit slots
  // -------------------------------------------------------------------
  localparam logic [3:0] CODE_ARRAY = 4'hA;       // normal array access
  localparam logic [3:0] CODE_FUSE_SET = 4'h6;    // protect register write
  localparam logic [3:0] CODE_FUSE_CLEAR = 4'h9;  // protect_fuse_clear_command
  localparam logic [3:0] LAST_BIT = 4'h7;         // eighth data bit
  localparam logic [3:0] ACK_SLOT = 4'h8;         // ninth clock
  localparam logic [7:0] PTR_RESET = 8'h00;       // pointer after reset
  localparam int DEPTH = 256;                     // array bytes
  // -------------------------------------------------------------------
  // link states
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle, st_ctrl, st_addr, st_wdata, st_read, st_absorb, st_ignore
  } link_state_t;
endpackage : eeprom_pkg

module pin_edge_sync import eeprom_pkg::*; #(
  parameter int SIDE_W = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // raw pins
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic [SIDE_W-1:0] side_pins,
  // conditioned outputs
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen,
  output logic sda_level,
  output logic [SIDE_W-1:0] side_level
);
  logic scl_meta, scl_s, scl_d;               // two stages plus history
  logic sda_meta, sda_s, sda_d;
  logic [SIDE_W-1:0] side_meta, side_s;
  // first stages only feed second stages; edges come from later stages
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_meta <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_meta <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      side_meta <= '0;
      side_s <= '0;
    end else begin
      scl_meta <= scl_pin;
      scl_s <= scl_meta;
      scl_d <= scl_s;
      sda_meta <= sda_pin;
      sda_s <= sda_meta;
      sda_d <= sda_s;
      side_meta <= side_pins;
      side_s <= side_meta;
    end
  end
  // edge and condition decode
  always_comb begin
    scl_rise = scl_s & ~scl_d;
    scl_fall = ~scl_s & scl_d;
    start_seen = scl_s & scl_d & sda_d & ~sda_s;   // data falls, clock high
    stop_seen = scl_s & scl_d & ~sda_d & sda_s;    // data rises, clock high
    sda_level = sda_s;
    side_level = side_s;
  end
endmodule : pin_edge_sync

// [serial_eeprom_read_and_protect.sv]
// two-wire eeprom slave: read paths, write protection and fuse clear
//
// What this block does
// - fuse clear prefix works only with elevated protect
// - protect pin high blocks every array write
// - protect pin high refuses setting protect register
// - protect pin low: register gates lower half
// - upper half guarded only by protect pin
// - pointer holds last accessed location plus one
// - current read: ack, one byte, release on nack
// - repeated start aborts write, keeps loaded pointer
// - master ack requests next sequential byte
// - pointer advances after every byte operation
// - sequential read never crosses into other devices
// - low supply inhibits erase and write logic
// - respond only when chip select bits match
// - data line driven low or released only
// - data changes only while clock is low
// - control byte: code, chip select, direction
// - set protect register: protect code not acknowledged
// - protected writes acknowledged, array left unchanged
// - no acknowledge during internal programming cycle
`timescale 1ns/1ps

module serial_eeprom_read_and_protect import eeprom_pkg::*; #(
  parameter int unsigned TWC_COUNT = TWC_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // two-wire bus, data line as three signals
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // straps and analogue detectors
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  input wire logic protect_pin,
  input wire logic protect_pin_elevated,
  input wire logic supply_low,
  // status
  output logic sw_protect,
  output logic write_busy
);
  // -------------------------------------------------------------------
  // elaboration check
  // -------------------------------------------------------------------
  if (TWC_COUNT < 1 || TWC_COUNT >= (1 << BUSY_W)) begin : g_bad_twc
    $error("TWC_COUNT does not fit the busy counter");
  end

  // -------------------------------------------------------------------
  // pin conditioning
  // -------------------------------------------------------------------
  logic scl_rise, scl_fall, start_seen, stop_seen, sda_level;
  logic [5:0] side_level;                        // cs2..0, prot, hv, low
  logic [2:0] cs;                                // strapped chip select
  logic prot_s, elevated_s, low_s;

  pin_edge_sync #(.SIDE_W(6)) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .scl_pin(scl_in),
    .sda_pin(sda_in),
    .side_pins({chip_select_bit2, chip_select_bit1, chip_select_bit0,
                protect_pin, protect_pin_elevated, supply_low}),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen),
    .sda_level(sda_level),
    .side_level(side_level)
  );

  assign cs = side_level[5:3];
  assign prot_s = side_level[2];
  assign elevated_s = side_level[1];
  assign low_s = side_level[0];

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  link_state_t state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;             // 0..7 data, 8 ack slot, 15 after start
  logic [7:0] shreg, next_shreg;                 // received byte
  logic [7:0] ptr, next_ptr;                     // address pointer
  logic [7:0] rd_byte, next_rd_byte;             // outgoing byte, msb first
  logic ack_flag, next_ack_flag;                 // master asked for more
  logic [7:0] wr_addr, next_wr_addr;             // pending write target
  logic [7:0] wr_data, next_wr_data;
  logic wr_valid, next_wr_valid;
  logic set_armed, next_set_armed;               // protect set pending
  logic clear_armed, next_clear_armed;           // fuse clear pending
  logic next_sw_protect, next_sda_oe, next_write_busy;
  logic [BUSY_W-1:0] busy_cnt, next_busy_cnt;
  logic mem_we;
  logic [7:0] mem [DEPTH];                       // the array itself

  // lower half follows the register, upper half only the pin
  function automatic logic write_blocked(input logic [7:0] a, input logic p,
                                         input logic sw);
    write_blocked = p | (~a[7] & sw);
  endfunction : write_blocked

  // -------------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rd_byte = rd_byte;
    next_ack_flag = ack_flag;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_valid = wr_valid;
    next_set_armed = set_armed;
    next_clear_armed = clear_armed;
    next_sw_protect = sw_protect;
    next_sda_oe = sda_oe;
    next_busy_cnt = busy_cnt;
    mem_we = 1'b0;
    // write cycle timer runs regardless of bus traffic
    if (busy_cnt != '0) begin
      next_busy_cnt = busy_cnt - BUSY_W'(1);
    end
    if (start_seen) begin
      // repeated start drops a pending write but keeps the pointer
      next_state = st_ctrl;
      // all ones: the clock fall that closes the start steps this to 0,
      // so that fall is not mistaken for the end of a data bit
      next_bit_cnt = '1;
      next_sda_oe = 1'b0;
      next_wr_valid = 1'b0;
      next_set_armed = 1'b0;
      next_clear_armed = 1'b0;
    end else if (stop_seen) begin
      next_state = st_idle;
      next_sda_oe = 1'b0;
      if (wr_valid || set_armed || clear_armed) begin
        // cycle time holds even if nothing is written
        next_busy_cnt = BUSY_W'(TWC_COUNT);
        if (!low_s) begin
          mem_we = wr_valid && !write_blocked(wr_addr, prot_s, sw_protect);
          if (set_armed && !prot_s) begin
            next_sw_protect = 1'b1;
          end
          if (clear_armed && elevated_s) begin
            next_sw_protect = 1'b0;
          end
        end
      end
      next_wr_valid = 1'b0;
      next_set_armed = 1'b0;
      next_clear_armed = 1'b0;
    end else if (scl_rise && state != st_idle && state != st_ignore) begin
      if (bit_cnt == ACK_SLOT) begin
        // sample master ack after a sent byte
        if (state == st_read) begin
          next_ack_flag = ~sda_level;
        end
      end else begin
        next_shreg = {shreg[6:0], sda_level};
      end
    end else if (scl_fall && state != st_idle && state != st_ignore) begin
      // every drive change sits on a falling clock edge
      if (bit_cnt == LAST_BIT) begin
        next_bit_cnt = ACK_SLOT;
        next_sda_oe = 1'b0;
        case (state)
          st_ctrl: begin
            // code, chip select, direction
            if (busy_cnt != '0 || shreg[3:1] != cs) begin
              next_state = st_ignore;
            end else if (shreg[7:4] == CODE_ARRAY) begin
              next_sda_oe = 1'b1;
              next_ack_flag = 1'b1;
              next_state = shreg[0] ? st_read : st_addr;
            end else if (shreg[7:4] == CODE_FUSE_SET && !shreg[0] &&
                         (!sw_protect || clear_armed)) begin
              next_sda_oe = 1'b1;
              next_set_armed = ~clear_armed;
              next_state = st_absorb;
            end else if (shreg[7:4] == CODE_FUSE_CLEAR && !shreg[0] &&
                         elevated_s) begin
              next_sda_oe = 1'b1;
              next_clear_armed = 1'b1;
            end else begin
              next_state = st_ignore;
            end
          end
          st_addr: begin
            next_ptr = shreg;
            next_sda_oe = 1'b1;
            next_state = st_wdata;
          end
          st_wdata: begin
            // acked even when protected; gating applies at stop
            next_wr_addr = ptr;
            next_wr_data = shreg;
            next_wr_valid = 1'b1;
            next_ptr = ptr + 8'h01;
            next_sda_oe = 1'b1;
          end
          st_absorb: begin
            next_sda_oe = 1'b1;
          end
          st_read: begin
            // release for master ack, then step with wrap
            next_ptr = ptr + 8'h01;
            next_ack_flag = 1'b0;
          end
          default: begin
            next_state = st_ignore;
          end
        endcase
      end else if (bit_cnt == ACK_SLOT) begin
        next_bit_cnt = '0;
        next_sda_oe = 1'b0;
        if (state == st_read) begin
          if (ack_flag) begin
            next_rd_byte = mem[ptr];
            next_sda_oe = ~mem[ptr][7];
          end else begin
            next_state = st_ignore;
          end
        end
      end else begin
        next_bit_cnt = bit_cnt + 4'h1;
        if (state == st_read) begin
          next_rd_byte = {rd_byte[6:0], 1'b0};
          next_sda_oe = ~rd_byte[6];
        end
      end
    end
    next_write_busy = (next_busy_cnt != '0);
  end

  // -------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= st_idle;
      bit_cnt <= '0;
      shreg <= '0;
      ptr <= PTR_RESET;
      rd_byte <= '0;
      ack_flag <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_valid <= 1'b0;
      set_armed <= 1'b0;
      clear_armed <= 1'b0;
      sw_protect <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      busy_cnt <= '0;
      write_busy <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rd_byte <= next_rd_byte;
      ack_flag <= next_ack_flag;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_valid <= next_wr_valid;
      set_armed <= next_set_armed;
      clear_armed <= next_clear_armed;
      sw_protect <= next_sw_protect;
      sda_oe <= next_sda_oe;
      sda_out <= 1'b0;                           // open drain, never high
      busy_cnt <= next_busy_cnt;
      write_busy <= next_write_busy;
    end
  end

  // array write port, no reset: contents are non-volatile
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic ctrl_end;
  assign ctrl_end = scl_fall && state == st_ctrl && bit_cnt == LAST_BIT && !start_seen
                    && !stop_seen;

  property p_open_drain;
    sda_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data driven high");

  property p_hw_protect;
    mem_we |-> !prot_s;
  endproperty
  a_hw_protect: assert property (p_hw_protect) else $error("write under pin");

  property p_sw_lower;
    mem_we && !wr_addr[7] |-> !sw_protect && !$rose(sw_protect);
  endproperty
  a_sw_lower: assert property (p_sw_lower) else $error("lower half written");

  property p_brownout;
    mem_we |-> !low_s;
  endproperty
  a_brownout: assert property (p_brownout) else $error("write at low supply");

  property p_no_set_prot;
    $rose(sw_protect) |-> !$past(prot_s) && $past(stop_seen);
  endproperty
  a_no_set_prot: assert property (p_no_set_prot) else $error("set under pin");

  property p_clear_hv;
    $fell(sw_protect) |-> $past(elevated_s) && $past(clear_armed);
  endproperty
  a_clear_hv: assert property (p_clear_hv) else $error("clear without hv");

  property p_busy_nack;
    ctrl_end && write_busy |=> !sda_oe ##1 !sda_oe;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while busy");

  property p_cs_match;
    ctrl_end && shreg[3:1] != cs |=> !sda_oe && state == st_ignore;
  endproperty
  a_cs_match: assert property (p_cs_match) else $error("ack on cs mismatch");

  property p_fuse_lock;
    ctrl_end && shreg[7:4] == CODE_FUSE_SET && sw_protect && !clear_armed |=> !sda_oe;
  endproperty
  a_fuse_lock: assert property (p_fuse_lock) else $error("protect code acked");

  property p_ptr_step;
    scl_fall && state == st_read && bit_cnt == LAST_BIT |=> ptr == $past(ptr) + 8'h01;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer not stepped");

  property p_drive_on_fall;
    $rose(sda_oe) |-> $past(scl_fall);
  endproperty
  a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive off edge");

  property p_nack_release;
    scl_fall && state == st_read && bit_cnt == ACK_SLOT && !ack_flag && !start_seen
      && !stop_seen |=> !sda_oe && state == st_ignore;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("drive after nack");

  c_seq_read: cover property (scl_fall && state == st_read && bit_cnt == ACK_SLOT && ack_flag);
  c_fuse_set: cover property ($rose(sw_protect));
  c_fuse_clear: cover property ($fell(sw_protect));
  c_upper_write: cover property (mem_we && wr_addr[7] && sw_protect);
endmodule : serial_eeprom_read_and_protect

// [bus_master.sv]
// two-wire bus master model: clock and open-drain data pull
`timescale 1ns/1ps

module bus_master (
  // bus pins driven by the master
  output logic scl,
  output logic sda_pull,
  // resolved data wire
  input wire logic sda
);
  // --------
  // idle bus
  // --------
  // clock parked high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // --------
  // bit level, 160 ns per bit
  // --------
  // data moves mid low phase, clear of both clock edges
  task automatic bit_io(input logic b, output logic s);
    #20 sda_pull = ~b;
    #40 scl = 1'b1;
    #40 s = sda;
    #40 scl = 1'b0;
    #20;
  endtask : bit_io

  // start, also serves as the repeated start
  task automatic start;
    #20 sda_pull = 1'b0;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40 scl = 1'b0;
    #20;
  endtask : start

  // stop leaves the clock still and high between frames
  task automatic stop;
    #20 sda_pull = 1'b1;
    #40 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #60;
  endtask : stop

  // --------
  // byte level
  // --------
  // msb first, then the acknowledge slot is sampled
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send

  // ack asks for the next byte, nack ends the read
  task automatic recv(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(~ack, s);
  endtask : recv
endmodule : bus_master

// [serial_eeprom_read_and_protect_bench.sv]
// self-checking bench for the eeprom read and protect block
`timescale 1ns/1ps

module serial_eeprom_read_and_protect_bench import eeprom_pkg::*;;
  // --------
  // clock, reset and pins
  // --------
  localparam int TWC = 2000; // shortened write cycle, still outlasts a frame
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic protect_pin = 1'b0;
  logic protect_pin_elevated = 1'b0;
  logic supply_low = 1'b0;
  logic [2:0] cs = 3'h5; // strap levels
  logic scl, sda_pull, sda_wire, sda_out, sda_oe, sw_protect, write_busy;
  logic a; // last ack seen
  logic [7:0] d; // last byte seen
  int bad_count = 0;
  int comparisons = 0;

  always #2.5 ref_clk = ~ref_clk;
  // pull-up unless either party pulls low
  assign sda_wire = (sda_oe | sda_pull) ? 1'b0 : 1'b1;

  serial_eeprom_read_and_protect #(.TWC_COUNT(TWC)) serial_eeprom_read_and_protect_inst (
    .ref_clk(ref_clk), .srst(srst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_bit0(cs[0]),
    .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]), .protect_pin(protect_pin),
    .protect_pin_elevated(protect_pin_elevated), .supply_low(supply_low),
    .sw_protect(sw_protect), .write_busy(write_busy));

  bus_master bus_master_inst (.scl(scl), .sda_pull(sda_pull), .sda(sda_wire));

  // --------
  // checking and verdict
  // --------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // the data pin is only ever pulled low; looked at mid-cycle, clear of the update edge
  always @(negedge ref_clk) begin
    if (sda_oe === 1'b1) begin
      check("drive level", 8'(sda_out), 8'h00);
    end
  end

  // --------
  // bus helpers
  // --------
  // a fixed offset after the edge keeps pin changes off the sampling edge
  task automatic at_edge;
    @(posedge ref_clk);
    #1;
  endtask : at_edge

  task automatic pins(input logic p, input logic e, input logic s);
    at_edge();
    protect_pin = p;
    protect_pin_elevated = e;
    supply_low = s;
  endtask : pins

  // bounded wait for the write cycle to end
  task automatic wait_idle;
    int n = 0;
    while (write_busy !== 1'b0) begin
      at_edge();
      n++;
      if (n > 3000) begin
        bad_count++;
        tally_and_finish();
      end
    end
  endtask : wait_idle

  function automatic logic [7:0] ctrl(input logic [3:0] code, input logic rw);
    return {code, cs, rw};
  endfunction : ctrl

  task automatic put(input logic [7:0] b, input logic exp);
    bus_master_inst.send(b, a);
    check("ack", 8'(a), 8'(exp));
  endtask : put

  // control byte plus two bytes, all acknowledged, then stop
  task automatic frame(input logic [7:0] c, input logic [7:0] b0, input logic [7:0] b1);
    wait_idle();
    bus_master_inst.start();
    put(c, 1'b1);
    put(b0, 1'b1);
    put(b1, 1'b1);
    bus_master_inst.stop();
  endtask : frame

  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    frame(ctrl(CODE_ARRAY, 1'b0), adr, dat);
  endtask : wr

  // refused control byte, frame then abandoned
  task automatic nack(input logic [7:0] c);
    bus_master_inst.start();
    put(c, 1'b0);
    bus_master_inst.stop();
  endtask : nack

  // random read when rnd, else current address; two bytes when two
  task automatic read(input logic rnd, input logic [7:0] adr, input logic two,
                      input logic [7:0] e0, input logic [7:0] e1);
    wait_idle();
    bus_master_inst.start();
    if (rnd) begin
      put(ctrl(CODE_ARRAY, 1'b0), 1'b1);
      put(adr, 1'b1);
      bus_master_inst.start();
    end
    put(ctrl(CODE_ARRAY, 1'b1), 1'b1);
    bus_master_inst.recv(two, d);
    check("first byte", d, e0);
    if (two) begin
      bus_master_inst.recv(1'b0, d);
      check("next byte", d, e1);
    end
    bus_master_inst.stop();
    check("released", 8'(sda_oe), 8'h00);
  endtask : read

  // --------
  // scenarios
  // --------
  // random, current after wrap, sequential across the half boundary
  task automatic s_reads;
    wr(8'h7F, 8'hA5);
    wr(8'h80, 8'h5A);
    wr(8'hFF, 8'h3C);
    wr(8'h00, 8'hC3);
    read(1'b1, 8'hFF, 1'b0, 8'h3C, 8'h00);
    read(1'b0, 8'h00, 1'b0, 8'hC3, 8'h00);
    read(1'b1, 8'h7F, 1'b1, 8'hA5, 8'h5A);
  endtask : s_reads

  // busy, wrong chip select, read on the protect code
  task automatic s_refuse;
    wr(8'h10, 8'h11);
    check("busy after stop", 8'(write_busy), 8'h01);
    nack(ctrl(CODE_ARRAY, 1'b1));
    wait_idle();
    nack({CODE_ARRAY, ~cs, 1'b1});
    nack(ctrl(CODE_FUSE_SET, 1'b1));
  endtask : s_refuse

  task automatic s_protect;
    pins(1'b1, 1'b0, 1'b0);
    frame(ctrl(CODE_FUSE_SET, 1'b0), 8'h00, 8'h00);
    check("set while pin high", 8'(sw_protect), 8'h00);
    wr(8'h80, 8'h11);
    read(1'b1, 8'h80, 1'b0, 8'h5A, 8'h00);
    pins(1'b0, 1'b0, 1'b0);
    frame(ctrl(CODE_FUSE_SET, 1'b0), 8'h00, 8'h00);
    check("set", 8'(sw_protect), 8'h01);
    wait_idle();
    nack(ctrl(CODE_FUSE_SET, 1'b0));
    wr(8'h7F, 8'h22);
    wr(8'h80, 8'h66);
    read(1'b1, 8'h7F, 1'b1, 8'hA5, 8'h66);
    pins(1'b0, 1'b0, 1'b1);
    wr(8'h80, 8'h77);
    pins(1'b0, 1'b0, 1'b0);
    read(1'b1, 8'h80, 1'b0, 8'h66, 8'h00);
  endtask : s_protect

  task automatic s_fuse;
    pins(1'b1, 1'b0, 1'b0);
    wait_idle();
    nack(ctrl(CODE_FUSE_CLEAR, 1'b0));
    check("kept", 8'(sw_protect), 8'h01);
    pins(1'b1, 1'b1, 1'b0);
    frame(ctrl(CODE_FUSE_CLEAR, 1'b0), ctrl(CODE_FUSE_SET, 1'b0), 8'h00);
    check("cleared", 8'(sw_protect), 8'h00);
    wait_idle();
    pins(1'b0, 1'b0, 1'b0);
    wr(8'h7F, 8'h99);
    read(1'b1, 8'h7F, 1'b0, 8'h99, 8'h00);
  endtask : s_fuse

  // --------
  // main sequence
  // --------
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 srst = 1'b0;
    repeat (4) at_edge();
    s_reads();
    s_refuse();
    s_protect();
    s_fuse();
    tally_and_finish();
  end
endmodule : serial_eeprom_read_and_protect_bench
